// >>> hdl/pmc_mode_ctrl.sv
// Purpose: Operating-mode control, watchdog debug handling, pre-regulator digital control
// Assumes: Pins synchronous except low-power request and wake two, which are synchronised
// Notes: Analog comparator results arrive already filtered
//
// Overview of operation
// - Debug keeps watchdog open, missing refresh tolerated
// - Fail-safe stays low in debug, released in normal on refresh or watchdog disabled
// - Start in OFF with all regulators disabled
// - Deep sleep keeps only hv regulator linear
// - Wake two detector active, starts turn-on
// - Deep sleep allow bit gates deep sleep
// - Wake two enters deep sleep when enabled
// - Hv regulator starts together with all others on entering normal
// - Standby on request toggle when both allows set
// - Standby forces buck PFM, hv linear mode
// - Kept switchers forced PFM, step-up never kept
// - Per-regulator keep bits select standby survivors
// - Normal runs configuration until sleep requested
// - Faults leave normal for OFF or deep fail-safe
// - Bias from battery below threshold, else regulator
// - Bias low undervoltage powers device down
// - Buck in PWM during normal operation
// - Overcurrent turns high side off until clock edge
// - Switching clock internal or external sync
// - Frequency select bit picks 455k or 2.2M
// - Pre-regulator comparators drive mode transitions
// - Overvolt or thermal in normal or standby goes straight to deep fail-safe
// - Wake one low exits deep fail-safe
`timescale 1ns/10ps
module pmc_mode_ctrl
    import pmc_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    input wire logic debug_entry_pin_i,
    input wire logic debug_exit_i,
    input wire logic init_fault_window_closed_i,
    input wire logic watchdog_disable_i,
    input wire logic watchdog_refresh_ok_i,
    input wire logic wake_input_one_i,
    input wire logic wake_input_two_i,
    input wire logic low_power_request_pin_i,
    input wire logic wake2_sleep_request_en_i,
    input wire logic off_request_i,
    input wire logic internal_fault_i,
    input wire logic external_fault_i,
    input wire logic overcurrent_i,
    input wire logic min_on_time_done_i,
    input wire logic sync_select_i,
    input wire logic sync_clock_in_i,
    input wire pmc_analog_t analog_i,
    input wire pmc_config_t config_i,
    output pmc_mode_t mode_o,
    output pmc_enables_t enables_o,
    output logic pre_reg_pfm_o,
    output logic switchers_pfm_o,
    output logic hv_linear_mode_o,
    output logic bias_from_battery_o,
    output logic watchdog_window_open_o,
    output logic failsafe_output_n_o,
    output logic high_side_on_o,
    output logic sw_clk_edge_o
);
    pmc_mode_t mode;
    logic [1:0] lp_sync;
    logic [1:0] w2_sync;
    logic lp_prev;
    logic w2_prev;
    logic [6:0] div_cnt;
    logic sync_prev;
    logic oc_hold;
    logic wd_disabled;
    logic released;
    logic lp_toggle;
    logic w2_rise;
    logic [6:0] div_max;
    pmc_enables_t next_enables;

    // Pin synchronisers; only second stage is evaluated
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            lp_sync <= 2'h0;
            w2_sync <= 2'h0;
            lp_prev <= 1'b0;
            w2_prev <= 1'b0;
        end else begin
            lp_sync <= {lp_sync[0], low_power_request_pin_i};
            w2_sync <= {w2_sync[0], wake_input_two_i};
            lp_prev <= lp_sync[1];
            w2_prev <= w2_sync[1];
        end
    end

    assign lp_toggle = lp_sync[1] ^ lp_prev;
    assign w2_rise = w2_sync[1] & ~w2_prev;

    // Main mode state machine
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            mode <= PMC_OFF;
        end else if (analog_i.bias_undervolt_low) begin
            mode <= PMC_OFF;
        end else begin
            case (mode)
                PMC_OFF: begin
                    if (wake_input_one_i || w2_sync[1]) begin
                        mode <= debug_entry_pin_i ? PMC_DEBUG : PMC_NORMAL;
                    end
                end
                PMC_DEBUG: begin
                    if (debug_exit_i && !debug_entry_pin_i) begin
                        mode <= PMC_NORMAL;
                    end
                end
                PMC_NORMAL: begin
                    if (analog_i.pre_reg_overvolt || analog_i.thermal_shutdown) begin
                        mode <= PMC_DEEP_FAILSAFE;
                    end else if (internal_fault_i || external_fault_i || off_request_i) begin
                        mode <= PMC_OFF;
                    end else if (analog_i.pre_reg_undervolt_low) begin
                        mode <= PMC_OFF;
                    end else if (config_i.deep_sleep_allow && wake2_sleep_request_en_i && w2_rise) begin
                        mode <= PMC_DEEP_SLEEP;
                    end else if (lp_toggle && config_i.low_power_allow && config_i.low_power_window_allow) begin
                        mode <= PMC_STANDBY;
                    end
                end
                PMC_STANDBY: begin
                    if (analog_i.pre_reg_overvolt || analog_i.thermal_shutdown) begin
                        mode <= PMC_DEEP_FAILSAFE;
                    end else if (lp_toggle || wake_input_one_i) begin
                        mode <= PMC_NORMAL;
                    end
                end
                PMC_DEEP_SLEEP: begin
                    if (w2_rise || wake_input_one_i) begin
                        mode <= PMC_NORMAL;
                    end
                end
                PMC_DEEP_FAILSAFE: begin
                    if (!wake_input_one_i) begin
                        mode <= PMC_OFF;
                    end
                end
                default: begin
                    mode <= PMC_OFF;
                end
            endcase
        end
    end

    assign mode_o = mode;

    // Regulator enables per mode
    always_comb begin
        next_enables = '0;
        case (mode)
            PMC_NORMAL: begin
                next_enables = '1;
                next_enables.hv_linear_reg = 1'b1;
            end
            PMC_STANDBY: begin
                next_enables.pre_reg = 1'b1;
                next_enables.step_down_reg = config_i.stepdown_keep_in_low_power;
                next_enables.ldo = config_i.ldo_keep_in_low_power;
                next_enables.hv_linear_reg = config_i.hv_keep_in_low_power;
                next_enables.step_up_converter = 1'b0;
            end
            PMC_DEEP_SLEEP: begin
                next_enables.hv_linear_reg = 1'b1;
            end
            default: begin
                next_enables = '0;
            end
        endcase
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            enables_o <= '0;
        end else begin
            enables_o <= next_enables;
        end
    end

    assign pre_reg_pfm_o = (mode == PMC_STANDBY);
    assign switchers_pfm_o = (mode == PMC_STANDBY);
    assign hv_linear_mode_o = (mode == PMC_STANDBY) || (mode == PMC_DEEP_SLEEP);
    assign bias_from_battery_o = analog_i.supply_below_select;

    // Watchdog disable and fail-safe release
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wd_disabled <= 1'b0;
            released <= 1'b0;
        end else begin
            if (watchdog_disable_i && !init_fault_window_closed_i) begin
                wd_disabled <= 1'b1;
            end
            if (mode == PMC_DEBUG) begin
                released <= 1'b0;
            end else if (mode == PMC_NORMAL && init_fault_window_closed_i
                         && (wd_disabled || watchdog_refresh_ok_i)) begin
                released <= 1'b1;
            end else if (mode == PMC_OFF || mode == PMC_DEEP_FAILSAFE) begin
                released <= 1'b0;
            end
        end
    end

    assign watchdog_window_open_o = (mode == PMC_DEBUG) || wd_disabled;
    assign failsafe_output_n_o = released;

    // Switching clock divider with external sync
    assign div_max = config_i.freq_select_high ? SW_HI_DIV : SW_LO_DIV;

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            div_cnt <= 7'h00;
            sync_prev <= 1'b0;
            sw_clk_edge_o <= 1'b0;
        end else begin
            sync_prev <= sync_clock_in_i;
            if (sync_select_i) begin
                sw_clk_edge_o <= sync_clock_in_i & ~sync_prev;
                div_cnt <= 7'h00;
            end else if (div_cnt >= div_max - 7'h01) begin
                sw_clk_edge_o <= 1'b1;
                div_cnt <= 7'h00;
            end else begin
                sw_clk_edge_o <= 1'b0;
                div_cnt <= div_cnt + 7'h01;
            end
        end
    end

    // High side cycle skip on overcurrent
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            oc_hold <= 1'b0;
        end else if (overcurrent_i && min_on_time_done_i) begin
            oc_hold <= 1'b1;
        end else if (sw_clk_edge_o) begin
            oc_hold <= 1'b0;
        end
    end

    assign high_side_on_o = enables_o.pre_reg && !oc_hold;

    AST_OFF_DISABLES: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        (mode == PMC_OFF) |=> (enables_o == '0)) else $error("regulator on in off");
    AST_DEEP_SLEEP_HV_ONLY: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        (mode == PMC_DEEP_SLEEP) |=> (enables_o.hv_linear_reg && !enables_o.pre_reg)) else $error("deep sleep enables");
    AST_STANDBY_NO_STEPUP: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        (mode == PMC_STANDBY) |-> pre_reg_pfm_o ##1 !enables_o.step_up_converter) else $error("standby step-up on");
    AST_NORMAL_PWM: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        (mode == PMC_NORMAL) |-> !pre_reg_pfm_o) else $error("pfm in normal");
    AST_OV_DEEP_FAILSAFE: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        (mode == PMC_NORMAL && analog_i.pre_reg_overvolt && !analog_i.bias_undervolt_low)
        |=> (mode == PMC_DEEP_FAILSAFE)) else $error("overvolt missed");
    AST_DFS_EXIT: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        (mode == PMC_DEEP_FAILSAFE && !wake_input_one_i) |=> (mode == PMC_OFF)) else $error("deep_failsafe exit");
    AST_NO_DSM_IF_DISALLOWED: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        (mode == PMC_NORMAL && !config_i.deep_sleep_allow) |=> (mode != PMC_DEEP_SLEEP)) else $error("deep sleep gated");
    AST_DEBUG_FS_LOW: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        (mode == PMC_DEBUG) [*2] |-> !failsafe_output_n_o && watchdog_window_open_o) else $error("debug fs");
    AST_BIAS_UV_OFF: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        analog_i.bias_undervolt_low |=> (mode == PMC_OFF)) else $error("bias uv");
    AST_OC_SKIP: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        (overcurrent_i && min_on_time_done_i) |=> !high_side_on_o) else $error("oc skip");
endmodule // pmc_mode_ctrl

// >>> hdl/pmc_pkg.sv
// Purpose: Shared types and constants for the operating-mode controller
// Assumes: One 25 MHz core clock
// Notes: Switching clock rates derived from the core clock
package pmc_pkg;
    localparam int CORE_CLK_KHZ = 25000;
    localparam int SW_LO_KHZ = 455;
    localparam int SW_HI_KHZ = 2200;
    localparam logic [6:0] SW_LO_DIV = 7'(CORE_CLK_KHZ / SW_LO_KHZ);
    localparam logic [6:0] SW_HI_DIV = 7'(CORE_CLK_KHZ / SW_HI_KHZ);
    localparam int N_STEPDOWN = 3;
    localparam int N_LDO = 3;

    typedef enum logic [5:0] {
        PMC_OFF = 6'h01,
        PMC_NORMAL = 6'h02,
        PMC_STANDBY = 6'h04,
        PMC_DEEP_SLEEP = 6'h08,
        PMC_DEEP_FAILSAFE = 6'h10,
        PMC_DEBUG = 6'h20
    } pmc_mode_t;

    typedef struct packed {
        logic pre_reg_undervolt_high;
        logic pre_reg_undervolt_low;
        logic pre_reg_overvolt;
        logic thermal_shutdown;
        logic bias_undervolt_low;
        logic supply_below_select;
    } pmc_analog_t;

    typedef struct packed {
        logic [N_STEPDOWN-1:0] stepdown_keep_in_low_power;
        logic [N_LDO-1:0] ldo_keep_in_low_power;
        logic hv_keep_in_low_power;
        logic deep_sleep_allow;
        logic low_power_allow;
        logic low_power_window_allow;
        logic freq_select_high;
    } pmc_config_t;

    typedef struct packed {
        logic [N_STEPDOWN-1:0] step_down_reg;
        logic [N_LDO-1:0] ldo;
        logic step_up_converter;
        logic hv_linear_reg;
        logic pre_reg;
    } pmc_enables_t;
endpackage

// >>> tb/pmc_host_model.sv
// Purpose: Host side of the mode pins, watchdog refresh and standby toggling
// Assumes: Commands from the bench arrive one cycle wide
// Notes: Refresh pulses every other cycle once the window closes
`timescale 1ns/10ps
module pmc_host_model (
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    input wire logic window_closed_i,
    input wire logic lp_toggle_i,
    output logic refresh_ok_o,
    output logic lp_pin_o
);
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            refresh_ok_o <= 1'h0;
            lp_pin_o <= 1'h0;
        end else begin
            refresh_ok_o <= window_closed_i & ~refresh_ok_o;
            if (lp_toggle_i) begin
                lp_pin_o <= ~lp_pin_o;
            end
        end
    end
endmodule // pmc_host_model

// >>> tb/pmc_mode_ctrl_tb.sv
// Purpose: Self-checking bench for the operating-mode controller
// Assumes: Inputs change 2 ns after the rising edge
// Notes: Deep sleep entry and debug flow are checked here as well as by the design assertions
`timescale 1ns/10ps
module pmc_mode_ctrl_tb;
    import pmc_pkg::*;
    logic clk = 1'h0, arst_n = 1'h0, wake1 = 1'h0, wake2 = 1'h0, wake2_en = 1'h0, win = 1'h0;
    logic oc = 1'h0, mot = 1'h0, fault = 1'h0, sync_sel = 1'h0, sync_clk = 1'h0, sync_run = 1'h0, lp_tg = 1'h0;
    logic dbg = 1'h0, dbg_exit = 1'h0, wd_dis = 1'h0;
    logic refresh, lp_pin, fs_n, pfm, sw_pfm, hv_lin, bias_bat, wd_open, hs_on, sw_edge;
    pmc_analog_t ana = '0;
    pmc_config_t cfg = '0;
    pmc_mode_t mode;
    pmc_enables_t en;
    int failures = 0, n_checks = 0, cyc = 0, p;
    always #20 clk = ~clk;
    always begin
        repeat (4) @(posedge clk);
        #2;
        if (sync_run) sync_clk = ~sync_clk;
    end
    pmc_host_model host (.core_clk_i(clk), .arst_n_i(arst_n), .window_closed_i(win), .lp_toggle_i(lp_tg),
        .refresh_ok_o(refresh), .lp_pin_o(lp_pin));
    pmc_mode_ctrl dut (.core_clk_i(clk), .arst_n_i(arst_n), .debug_entry_pin_i(dbg), .debug_exit_i(dbg_exit),
        .init_fault_window_closed_i(win), .watchdog_disable_i(wd_dis), .watchdog_refresh_ok_i(refresh),
        .wake_input_one_i(wake1), .wake_input_two_i(wake2), .low_power_request_pin_i(lp_pin),
        .wake2_sleep_request_en_i(wake2_en), .off_request_i(1'h0), .internal_fault_i(fault),
        .external_fault_i(1'h0), .overcurrent_i(oc), .min_on_time_done_i(mot), .sync_select_i(sync_sel),
        .sync_clock_in_i(sync_clk), .analog_i(ana), .config_i(cfg), .mode_o(mode), .enables_o(en),
        .pre_reg_pfm_o(pfm), .switchers_pfm_o(sw_pfm), .hv_linear_mode_o(hv_lin), .bias_from_battery_o(bias_bat),
        .watchdog_window_open_o(wd_open), .failsafe_output_n_o(fs_n), .high_side_on_o(hs_on),
        .sw_clk_edge_o(sw_edge));
    function automatic logic [31:0] low_power_request_pin_en(input pmc_config_t c);
        pmc_enables_t e;
        e.step_down_reg = c.stepdown_keep_in_low_power;
        e.ldo = c.ldo_keep_in_low_power;
        e.step_up_converter = 1'h0;
        e.hv_linear_reg = c.hv_keep_in_low_power;
        e.pre_reg = 1'h1;
        return 32'(e);
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic period(output int q);
        int i;
        i = 0;
        while (sw_edge !== 1'h1 && i < 300) begin tick(1); i++; end
        tick(1);
        q = 1;
        while (sw_edge !== 1'h1 && q < 300) begin tick(1); q++; end
    endtask
    task automatic toggle_lp();
        lp_tg = 1'h1;
        tick(1);
        lp_tg = 1'h0;
        tick(6);
    endtask
    task automatic close_out();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin failures++; close_out(); end
    end
    initial begin
        void'($urandom(32'hb5ce));
        tick(3);
        chk("mode", 32'(mode), 32'(PMC_OFF));
        chk("enables", 32'(en), 32'h0);
        chk("failsafe", 32'(fs_n), 32'h0);
        arst_n = 1'h1;
        tick(1);
        wake1 = 1'h1;
        tick(2);
        chk("mode", 32'(mode), 32'(PMC_NORMAL));
        tick(1);
        chk("enables", 32'(en), 32'h1ff);
        chk("pfm", 32'(pfm), 32'h0);
        win = 1'h1;
        tick(4);
        chk("failsafe", 32'(fs_n), 32'h1);
        period(p);
        chk("period lo", 32'(p), 32'(CORE_CLK_KHZ / SW_LO_KHZ));
        cfg.freq_select_high = 1'h1;
        period(p);
        period(p);
        chk("period hi", 32'(p), 32'(CORE_CLK_KHZ / SW_HI_KHZ));
        sync_sel = 1'h1;
        sync_run = 1'h1;
        repeat (2) period(p);
        chk("period sync", 32'(p), 32'h8);
        oc = 1'h1;
        mot = 1'h1;
        tick(1);
        chk("high side", 32'(hs_on), 32'h0);
        oc = 1'h0;
        for (int i = 0; i < 8; i++) begin
            ana.supply_below_select = 1'($urandom);
            #1;
            chk("bias", 32'(bias_bat), 32'(ana.supply_below_select));
        end
        ana.supply_below_select = 1'h0;
        wake2_en = 1'h1;
        wake2 = 1'h1;
        tick(6);
        wake2 = 1'h0;
        tick(6);
        chk("mode", 32'(mode), 32'(PMC_NORMAL));
        toggle_lp();
        chk("mode", 32'(mode), 32'(PMC_NORMAL));
        cfg.low_power_allow = 1'h1;
        cfg.low_power_window_allow = 1'h1;
        cfg.stepdown_keep_in_low_power = 3'($urandom);
        cfg.ldo_keep_in_low_power = 3'($urandom);
        cfg.hv_keep_in_low_power = 1'($urandom);
        wake1 = 1'h0;
        toggle_lp();
        chk("mode", 32'(mode), 32'(PMC_STANDBY));
        chk("pfm", 32'(pfm), 32'h1);
        chk("hv linear", 32'(hv_lin), 32'h1);
        chk("switchers pfm", 32'(sw_pfm), 32'h1);
        chk("enables", 32'(en), low_power_request_pin_en(cfg));
        toggle_lp();
        chk("mode", 32'(mode), 32'(PMC_NORMAL));
        cfg.deep_sleep_allow = 1'h1;
        wake2 = 1'h1;
        tick(4);
        chk("mode", 32'(mode), 32'(PMC_DEEP_SLEEP));
        chk("enables", 32'(en), 32'h2);
        chk("hv linear", 32'(hv_lin), 32'h1);
        wake2 = 1'h0;
        tick(3);
        wake2 = 1'h1;
        tick(4);
        chk("mode", 32'(mode), 32'(PMC_NORMAL));
        wake2 = 1'h0;
        wake1 = 1'h1;
        tick(3);
        ana.pre_reg_overvolt = 1'h1;
        tick(3);
        chk("mode", 32'(mode), 32'(PMC_DEEP_FAILSAFE));
        ana.pre_reg_overvolt = 1'h0;
        wake1 = 1'h0;
        tick(3);
        chk("left failsafe", 32'(mode == PMC_DEEP_FAILSAFE), 32'h0);
        wake1 = 1'h1;
        tick(3);
        fault = 1'h1;
        wake1 = 1'h0;
        tick(3);
        chk("fault exit", 32'(mode inside {PMC_OFF, PMC_DEEP_FAILSAFE}), 32'h1);
        fault = 1'h0;
        wake1 = 1'h0;
        tick(3);
        wake1 = 1'h1;
        tick(3);
        ana.bias_undervolt_low = 1'h1;
        tick(3);
        chk("mode", 32'(mode), 32'(PMC_OFF));
        ana.bias_undervolt_low = 1'h0;
        arst_n = 1'h0;
        win = 1'h0;
        dbg = 1'h1;
        tick(1);
        arst_n = 1'h1;
        chk("mode", 32'(mode), 32'(PMC_OFF));
        tick(3);
        chk("mode", 32'(mode), 32'(PMC_DEBUG));
        chk("wd open", 32'(wd_open), 32'h1);
        wd_dis = 1'h1;
        tick(1);
        wd_dis = 1'h0;
        tick(3);
        chk("failsafe", 32'(fs_n), 32'h0);
        dbg = 1'h0;
        dbg_exit = 1'h1;
        tick(2);
        dbg_exit = 1'h0;
        chk("mode", 32'(mode), 32'(PMC_NORMAL));
        win = 1'h1;
        tick(3);
        chk("failsafe", 32'(fs_n), 32'h1);
        close_out();
    end
endmodule // pmc_mode_ctrl_tb
